//--- rtl/reset_cause_pkg.sv
// Constants for the reset cause and power-save history block.
// Assumes an APB slave at 100 MHz; all users write reset_cause_pkg::name.
package reset_cause_pkg;
  localparam logic [11:0] ADDR_CAUSE   = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_CONTROL = 12'h00c;
  localparam int          BIT_TRAP     = 15;
  localparam int          BIT_ILLEGAL  = 14;
  localparam int          BIT_MISMATCH = 9;
  localparam int          BIT_VREG     = 8;
  localparam int          BIT_EXTERN   = 7;
  localparam int          BIT_INSTR    = 6;
  localparam int          BIT_SWDT     = 5;
  localparam int          BIT_WATCHDOG_TIMEOUT_FLAG     = 4;
  localparam int          BIT_SLEEP    = 3;
  localparam int          BIT_IDLE     = 2;
  localparam int          BIT_BROWN    = 1;
  localparam int          BIT_POWER    = 0;
  localparam logic [15:0] CAUSE_MASK   = 16'hc3ff;
  localparam logic [15:0] CAUSE_POR    = 16'h0003;
  localparam int          EVT_N        = 8;
  localparam int          OSC_W        = 3;
  localparam logic [2:0]  OSC_RESET    = 3'h0;
  localparam int          CTRL_OSC_LSB = 0;
  localparam int          CTRL_WDT     = 4;
  localparam int          CTRL_SWITCH  = 5;
  localparam int          RST_CYCLES   = 4;
endpackage

//--- rtl/reset_pulse_stretch.sv
// Stretches a one-cycle reset request into a fixed-length reset pulse.
// Assumes request is synchronous to pclk.
`timescale 1ns/1ps
module reset_pulse_stretch #(
  parameter int LEN = reset_cause_pkg::RST_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic request,
  output logic      active
);
  logic [7:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= 8'h00;
      active <= 1'b0;
    end else if (request) begin
      count  <= 8'(LEN);
      active <= 1'b1;
    end else if (count != 8'h00) begin
      count  <= count - 8'h01;
      active <= (count != 8'h01);
    end else begin
      active <= 1'b0;
    end
  end
endmodule

//--- rtl/reset_cause_flags.sv
// Reset cause register, watchdog enable, clock choice and interrupt logic.
// Assumes an APB master on pclk; event inputs are pins, synchronised here.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module reset_cause_flags #(
  parameter int RST_LEN = reset_cause_pkg::RST_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_on_event,
  input  wire logic        brownout_event,
  input  wire logic        master_clear_pin_n,
  input  wire logic        reset_instruction,
  input  wire logic        watchdog_expired,
  input  wire logic        trap_conflict_event,
  input  wire logic        illegal_operation_event,
  input  wire logic        config_mismatch_event,
  input  wire logic        sleep_entry,
  input  wire logic        idle_entry,
  input  wire logic        watchdog_config_enable,
  input  wire logic        clock_switch_enable,
  input  wire logic [2:0]  initial_oscillator_select,
  input  wire logic [2:0]  next_oscillator_request,
  output logic             master_system_reset,
  output logic             watchdog_enabled,
  output logic             regulator_standby_control,
  output logic [2:0]       current_oscillator_field,
  output logic             irq
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int N = reset_cause_pkg::EVT_N + 4;
  logic [N-1:0] raw;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-3:0] sync3;
  logic [N-3:0] rise;

  assign raw = {watchdog_config_enable, clock_switch_enable, sleep_entry, idle_entry,
                power_on_event, brownout_event, ~master_clear_pin_n, reset_instruction,
                watchdog_expired, trap_conflict_event, illegal_operation_event,
                config_mismatch_event};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2[N-3:0];
    end
  end

  // Edge detect so a held level records once
  // Top two bits are config levels and take no edge detect
  genvar g;
  generate
    for (g = 0; g < N - 2; g++) begin : g_edge
      assign rise[g] = sync2[g] & ~sync3[g];
    end
  endgenerate

  logic ev_mismatch, ev_illegal, ev_trap, ev_wdt, ev_instr, ev_pin, ev_brown, ev_por;
  logic ev_idle, ev_sleep, cfg_wdt, cfg_switch;
  assign ev_mismatch = rise[0];
  assign ev_illegal  = rise[1];
  assign ev_trap     = rise[2];
  assign ev_wdt      = rise[3];
  assign ev_instr    = rise[4];
  assign ev_pin      = rise[5];
  assign ev_brown    = rise[6];
  assign ev_por      = rise[7];
  assign ev_idle     = rise[8];
  assign ev_sleep    = rise[9];
  assign cfg_switch  = sync2[10];
  assign cfg_wdt     = sync2[11];

  // Either power-save entry counts as the instruction
  logic ev_power_save;
  assign ev_power_save = ev_sleep | ev_idle;

  // ****************************************
  // APB decode
  // ****************************************
  // Zero-wait slave: every access phase lasts one cycle
  logic        wr;
  logic        access;
  logic [15:0] wd;
  logic        hit;
  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign wd     = pwdata[15:0];
  assign hit    = (paddr == reset_cause_pkg::ADDR_CAUSE) |
                  (paddr == reset_cause_pkg::ADDR_STATUS) |
                  (paddr == reset_cause_pkg::ADDR_MASK) |
                  (paddr == reset_cause_pkg::ADDR_CONTROL);

  // ****************************************
  // Cause register
  // ****************************************
  logic [15:0] cause;
  logic [15:0] next_cause;
  logic [15:0] hw_set;

  always_comb begin
    hw_set = '0;
    hw_set[reset_cause_pkg::BIT_TRAP]     = ev_trap;
    hw_set[reset_cause_pkg::BIT_MISMATCH] = ev_mismatch;
    hw_set[reset_cause_pkg::BIT_EXTERN]   = ev_pin;
    hw_set[reset_cause_pkg::BIT_INSTR]    = ev_instr;
    hw_set[reset_cause_pkg::BIT_ILLEGAL]  = ev_illegal;
    hw_set[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]     = ev_wdt;
    hw_set[reset_cause_pkg::BIT_SLEEP]    = ev_sleep;
    hw_set[reset_cause_pkg::BIT_IDLE]     = ev_idle;
    hw_set[reset_cause_pkg::BIT_BROWN]    = ev_brown | ev_por;
    hw_set[reset_cause_pkg::BIT_POWER]    = ev_por;
  end

  always_comb begin
    next_cause = cause;
    if (wr && paddr == reset_cause_pkg::ADDR_CAUSE) begin
      next_cause = wd & reset_cause_pkg::CAUSE_MASK;
    end
    if (ev_power_save) begin
      next_cause[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    // Hardware set wins over a same-cycle clear
    next_cause = next_cause | hw_set;
    if (ev_por) begin
      next_cause = reset_cause_pkg::CAUSE_POR;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= reset_cause_pkg::CAUSE_POR;
    end else begin
      cause <= next_cause;
    end
  end

  // ****************************************
  // Watchdog enable and regulator
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Held on only until the first clock, before the synced config is known
      watchdog_enabled          <= 1'b1;
      regulator_standby_control <= 1'b0;
    end else begin
      watchdog_enabled          <= cfg_wdt | cause[reset_cause_pkg::BIT_SWDT];
      regulator_standby_control <= cause[reset_cause_pkg::BIT_VREG];
    end
  end

  // ****************************************
  // Master reset
  // ****************************************
  // any source asserts reset
  // software writes never feed this term
  logic any_source;
  logic stretched;
  assign any_source = ev_por | ev_brown | ev_pin | ev_instr | ev_wdt |
                      ev_trap | ev_illegal | ev_mismatch;

  reset_pulse_stretch #(
    .LEN (RST_LEN)
  ) u_stretch (
    .pclk    (pclk),
    .presetn (presetn),
    .request (any_source),
    .active  (stretched)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_system_reset <= 1'b1;
    end else begin
      // Source term joins at once; the stretcher keeps it up
      master_system_reset <= stretched | any_source;
    end
  end

  // ****************************************
  // Oscillator choice at reset and on switch request
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_oscillator_field <= reset_cause_pkg::OSC_RESET;
    end else if (!cfg_switch && (any_source || master_system_reset)) begin
      // configured source always
      // Loaded while reset stands, so a bus reset starts here too
      current_oscillator_field <= initial_oscillator_select;
    end else if (cfg_switch && (ev_por | ev_brown)) begin
      current_oscillator_field <= initial_oscillator_select;
    end else if (cfg_switch && !any_source && !master_system_reset) begin
      current_oscillator_field <= next_oscillator_request;
    end
  end

  // ****************************************
  // Control readback word
  // ****************************************
  // Read-only view of synced config and the live clock field
  logic [15:0] control_word;

  always_comb begin
    control_word = '0;
    control_word[reset_cause_pkg::CTRL_OSC_LSB +: reset_cause_pkg::OSC_W] =
      current_oscillator_field;
    control_word[reset_cause_pkg::CTRL_WDT]    = cfg_wdt;
    control_word[reset_cause_pkg::CTRL_SWITCH] = cfg_switch;
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Status shares the cause layout, so one mask serves every event
  logic [15:0] status;
  logic [15:0] mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      mask   <= '0;
    end else begin
      // Set wins over write-one-to-clear
      if (wr && paddr == reset_cause_pkg::ADDR_STATUS) begin
        status <= (status & ~wd) | hw_set;
      end else begin
        status <= status | hw_set;
      end
      if (wr && paddr == reset_cause_pkg::ADDR_MASK) begin
        mask <= wd;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  // Latched in setup so the data stands exactly with pready
  logic [31:0] read_word;

  always_comb begin
    read_word = '0;
    unique case (paddr)
      reset_cause_pkg::ADDR_CAUSE:   read_word = {16'h0000, cause};
      reset_cause_pkg::ADDR_STATUS:  read_word = {16'h0000, status};
      reset_cause_pkg::ADDR_MASK:    read_word = {16'h0000, mask};
      reset_cause_pkg::ADDR_CONTROL: read_word = {16'h0000, control_word};
      default:                       read_word = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        prdata <= read_word;
      end
    end
  end
endmodule

//--- bench/reset_cause_chk.sv
// Concurrent checks on the ports of the reset cause block.
// Assumes every event input is held high for three cycles or more.
`timescale 1ns/1ps
module reset_cause_chk #(
  parameter int RST_LEN = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        power_on_event,
  input wire logic        brownout_event,
  input wire logic        master_clear_pin_n,
  input wire logic        reset_instruction,
  input wire logic        watchdog_expired,
  input wire logic        trap_conflict_event,
  input wire logic        illegal_operation_event,
  input wire logic        config_mismatch_event,
  input wire logic        watchdog_config_enable,
  input wire logic        clock_switch_enable,
  input wire logic [2:0]  initial_oscillator_select,
  input wire logic        master_system_reset,
  input wire logic        watchdog_enabled,
  input wire logic        regulator_standby_control,
  input wire logic [2:0]  current_oscillator_field
);
  // Sync and stretch latency bound the wait for the reset
  localparam int SRC_MAX = RST_LEN + 4;
  logic ev_any;
  logic cwr;
  assign ev_any = power_on_event | brownout_event | !master_clear_pin_n | reset_instruction
                | watchdog_expired | trap_conflict_event | illegal_operation_event
                | config_mismatch_event;
  assign cwr = penable && pready && pwrite && (paddr == reset_cause_pkg::ADDR_CAUSE);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Properties
  // ****************************************
  AST_NO_WAIT: assert property (penable |-> pready)
    else $error("access cycle without ready");
  AST_SRC_RESET: assert property ($rose(ev_any) |-> ##[1:SRC_MAX] master_system_reset)
    else $error("reset source gave no system reset");
  AST_STRETCH: assert property ($rose(master_system_reset) |-> master_system_reset[*5])
    else $error("system reset too short");
  AST_ONLY_SRC: assert property ($rose(master_system_reset) |->
    $past(ev_any, 3) || $past(ev_any, 4) || $past(ev_any, 5) || $past(ev_any, 6))
    else $error("system reset without a source");
  AST_WDT_FORCED: assert property (watchdog_config_enable[*5] |=> watchdog_enabled)
    else $error("watchdog not forced on");
  AST_WDT_SW: assert property ((!watchdog_config_enable)[*5] ##0 cwr |->
    ##2 watchdog_enabled == $past(pwdata[5], 2))
    else $error("watchdog enable not from software bit");
  AST_STANDBY: assert property (cwr |-> ##2 regulator_standby_control == $past(pwdata[8], 2))
    else $error("standby control not written");
  AST_OSC_FIXED: assert property (master_system_reset[*3] ##1
    (!master_system_reset && !clock_switch_enable) |->
    current_oscillator_field == initial_oscillator_select)
    else $error("clock not from configuration after reset");
endmodule

bind reset_cause_flags reset_cause_chk #(.RST_LEN(RST_LEN)) chk_i (
  .pclk, .presetn, .penable, .pwrite, .paddr, .pwdata, .pready, .power_on_event,
  .brownout_event, .master_clear_pin_n, .reset_instruction, .watchdog_expired,
  .trap_conflict_event, .illegal_operation_event, .config_mismatch_event,
  .watchdog_config_enable, .clock_switch_enable, .initial_oscillator_select,
  .master_system_reset, .watchdog_enabled, .regulator_standby_control, .current_oscillator_field
);

//--- bench/tb_top.sv
// Self-checking bench for the reset cause block over APB.
// Assumes the checker is bound in; events are driven as 3-cycle pulses.
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] CA = reset_cause_pkg::ADDR_CAUSE;
  localparam logic [11:0] ST = reset_cause_pkg::ADDR_STATUS;
  localparam logic [11:0] MK = reset_cause_pkg::ADDR_MASK;
  localparam logic [11:0] CT = reset_cause_pkg::ADDR_CONTROL;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic        cfg, cse, msr, wd_en, rsc, irq, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  init_osc, nreq, osc, o;
  logic [9:0]  ev;
  logic [15:0] expv [10];
  int          errors, n_checks;

  reset_cause_flags dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_event(ev[0]), .brownout_event(ev[1]), .master_clear_pin_n(!ev[2]),
    .reset_instruction(ev[3]), .watchdog_expired(ev[4]), .trap_conflict_event(ev[5]),
    .illegal_operation_event(ev[6]), .config_mismatch_event(ev[7]), .sleep_entry(ev[8]),
    .idle_entry(ev[9]), .watchdog_config_enable(cfg), .clock_switch_enable(cse),
    .initial_oscillator_select(init_osc), .next_oscillator_request(nreq),
    .master_system_reset(msr), .watchdog_enabled(wd_en), .regulator_standby_control(rsc),
    .current_oscillator_field(osc), .irq(irq)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("[FAIL] apb_ready expected 1 seen %b", pready);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse one event; note whether reset came and the clock chosen under it
  task automatic fire(input int i);
    s = 1'b0;
    @(posedge pclk);
    ev[i] <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      @(posedge pclk);
      if (c == 2) ev[i] <= 1'b0;
      if (msr === 1'b1) begin
        s = 1'b1;
        o = osc;
      end
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #200000;
    errors++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, cfg, cse} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ev = 10'h0;
    init_osc = 3'h5;
    nreq = 3'h2;
    errors = 0;
    n_checks = 0;
    expv = '{16'h0003, 16'h0002, 16'h0080, 16'h0040, 16'h0010,
             16'h8000, 16'h4000, 16'h0200, 16'h0008, 16'h0004};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CA, 32'h0);
    chk("cause_reset", 32'h3, r);
    chk("osc_reset", 32'h5, osc);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, CA, (i == 0) ? 32'hc3fc : (i > 7) ? 32'h10 : 32'h0);
      fire(i);
      apb(1'b0, CA, 32'h0);
      chk("cause_event", {16'h0, expv[i]}, r);
      chk("reset_seen", i < 8, s);
    end
    apb(1'b1, CA, 32'hc3ff);
    repeat (8) @(posedge pclk);
    chk("sw_no_reset", 32'h0, msr);
    chk("standby", 32'h1, rsc);
    apb(1'b0, CA, 32'h0);
    chk("cause_rw", 32'hc3ff, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, last_err);
    apb(1'b1, ST, 32'hffff);
    apb(1'b1, MK, 32'h8000);
    fire(5);
    chk("irq_set", 32'h1, irq);
    apb(1'b1, ST, 32'h8000);
    repeat (2) @(posedge pclk);
    chk("irq_clear", 32'h0, irq);
    fire(6);
    chk("irq_masked", 32'h0, irq);
    apb(1'b0, ST, 32'h0);
    chk("status_masked", 32'h4000, r);
    apb(1'b1, CA, 32'h0);
    cfg <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("wdt_forced", 32'h1, wd_en);
    cfg <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("wdt_off", 32'h0, wd_en);
    apb(1'b1, CA, 32'h20);
    repeat (3) @(posedge pclk);
    chk("wdt_sw", 32'h1, wd_en);
    fire(3);
    chk("osc_fixed", 32'h5, o);
    cse <= 1'b1;
    init_osc <= 3'h6;
    repeat (4) @(posedge pclk);
    fire(1);
    chk("osc_brownout", 32'h6, o);
    fire(2);
    chk("osc_keep", 32'h2, o);
    apb(1'b0, CT, 32'h0);
    chk("control", 32'h22, r);
    results();
  end
endmodule
